/* File: hw/srsm_top.sv */
`include "srsm_defs.svh"

module srsm_top #(
   parameter int DEB_CYC = (`SRSM_DEB_US * `SRSM_CLK_KHZ + 999) / 1000,
   parameter int SETTLE_CYC = `SRSM_SETTLE_MS * `SRSM_CLK_KHZ,
   parameter int ON_CYC = `SRSM_ON_DELAY_MS * `SRSM_CLK_KHZ,
   parameter int BLINK_CYC = `SRSM_BLINK_HALF_MS * `SRSM_CLK_KHZ
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic first_input_channel_i,
   input wire logic second_input_channel_i,
   input wire logic start_reset_input_i,
   input wire logic feedback_i,
   input wire logic contact_short_i,
   input wire logic terminator_i,
   input wire logic internal_fault_i,
   input wire logic undervolt_i,
   input wire logic channel_short_i,
   input wire logic [2:0] mode_i,
   input wire logic [1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic relay_o,
   output logic aux_status_output_o,
   output logic led_power_o,
   output logic first_channel_indicator_o,
   output logic second_channel_indicator_o,
   output logic led_output_o,
   output logic led_reset_o,
   output logic led_fault_o
);

   logic [`SRSM_NIN-1:0] pin_vec;
   logic [`SRSM_NIN-1:0] db;
   logic ch1;
   logic ch2;
   logic start;
   logic start_prev;
   logic start_rise;
   logic [2:0] mode_now;
   logic [2:0] mode_cfg;
   logic [31:0] settle_cnt;
   logic cfg_done;
   logic [31:0] delay_cnt;
   logic [31:0] blink_cnt;
   logic blink;
   logic [7:0] ctrl;
   logic both_open;
   logic ch1_prev;
   logic ch2_prev;
   logic latched;
   logic permit;
   logic in_closed;
   logic ok;
   srsm_pkg::srsm_err_t err;
   srsm_pkg::srsm_led_t next_led;
   srsm_pkg::srsm_state_t state;
   srsm_pkg::srsm_state_t next_state;

   assign pin_vec = {mode_i, channel_short_i, undervolt_i, internal_fault_i,
                     terminator_i, contact_short_i, feedback_i,
                     start_reset_input_i, second_input_channel_i,
                     first_input_channel_i};

   // Three-stage sync, then a hold time before a new level is believed
   genvar gi;
   generate
      for (gi = 0; gi < `SRSM_NIN; gi++) begin : g_in
         logic s1;
         logic s2;
         logic s3;
         logic q;
         logic [31:0] cnt;
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
            end else begin
               s1 <= pin_vec[gi];
               s2 <= s1;
               s3 <= s2;
            end
         end
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               q <= 1'b0;
               cnt <= 32'h0;
            end else if (s2 != s3 || s3 == q) begin
               cnt <= 32'h0;
            end else if (cnt >= DEB_CYC - 1) begin
               q <= s3;
               cnt <= 32'h0;
            end else begin
               cnt <= cnt + 32'h1;
            end
         end
         assign db[gi] = q;
      end
   endgenerate

   assign ch1 = db[`SRSM_IX_CH1];
   assign ch2 = db[`SRSM_IX_CH2];
   assign start = db[`SRSM_IX_START];
   assign mode_now = db[`SRSM_IX_MODE_HI:`SRSM_IX_MODE_LO];
   assign start_rise = start & ~start_prev;

   // Selector is read once the inputs have settled after power-up
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         settle_cnt <= 32'h0;
         cfg_done <= 1'b0;
         mode_cfg <= `SRSM_MODE_VERT;
      end else if (!cfg_done) begin
         if (settle_cnt >= SETTLE_CYC - 1) begin
            cfg_done <= 1'b1;
            mode_cfg <= mode_now;
         end else begin
            settle_cnt <= settle_cnt + 32'h1;
         end
      end
   end

   // Only a power cycle, seen as reset, clears these, except blk1 and blk2, cleared when both channels close after both opened
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         err.shrt <= 1'b0;
         err.term <= 1'b0;
         err.intf <= 1'b0;
         err.conn <= 1'b0;
         err.mode <= 1'b0;
         err.vert <= 1'b0;
         err.blk1 <= 1'b0;
         err.blk2 <= 1'b0;
         ch1_prev <= 1'b0;
         ch2_prev <= 1'b0;
         both_open <= 1'b0;
      end else if (cfg_done) begin
         if (db[`SRSM_IX_CSHORT]) begin
            err.shrt <= 1'b1;
         end
         if (!db[`SRSM_IX_TERM]) begin
            err.term <= 1'b1;
         end
         if (db[`SRSM_IX_INTF]) begin
            err.intf <= 1'b1;
         end
         if (db[`SRSM_IX_XSHORT]) begin
            err.conn <= 1'b1;
         end
         if (mode_cfg > `SRSM_MODE_FALL || mode_now != mode_cfg) begin
            err.mode <= 1'b1;
         end
         if (mode_cfg == `SRSM_MODE_VERT) begin
            err.vert <= 1'b1;
         end
         // Simultaneity watch: a lone channel reclosing blocks start-up
         ch1_prev <= ch1;
         ch2_prev <= ch2;
         if (!ch1 && !ch2) begin
            both_open <= 1'b1;
         end else if (ch1 && ch2 && both_open) begin
            both_open <= 1'b0;
            err.blk1 <= 1'b0;
            err.blk2 <= 1'b0;
         end
         if (ch1 && !ch1_prev && ch2 && ch2_prev && !both_open) begin
            err.blk1 <= 1'b1;
         end
         if (ch2 && !ch2_prev && ch1 && ch1_prev && !both_open) begin
            err.blk2 <= 1'b1;
         end
      end
   end

   assign latched = err.shrt | err.term | err.intf | err.conn | err.mode | err.vert;
   assign permit = cfg_done & ~latched & ~err.blk1 & ~err.blk2
                   & ~db[`SRSM_IX_UV] & ~ctrl[`SRSM_CTRL_FORCE_OFF];
   assign in_closed = ch1 & ch2;
   assign ok = permit & in_closed;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_prev <= 1'b0;
      end else begin
         start_prev <= start;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         srsm_pkg::ST_WAIT: begin
            // Released contacts must be seen before any new start
            if (ok && db[`SRSM_IX_FB]) begin
               if (mode_cfg == `SRSM_MODE_AUTO) begin
                  next_state = srsm_pkg::ST_DELAY;
               end else begin
                  next_state = srsm_pkg::ST_ARMED;
               end
            end
         end
         srsm_pkg::ST_ARMED: begin
            if (!ok) begin
               next_state = srsm_pkg::ST_WAIT;
            end else if (mode_cfg == `SRSM_MODE_MANUAL && start) begin
               next_state = srsm_pkg::ST_DELAY;
            end else if (mode_cfg == `SRSM_MODE_RISE && start_rise) begin
               next_state = srsm_pkg::ST_DELAY;
            end else if (mode_cfg == `SRSM_MODE_FALL && start) begin
               next_state = srsm_pkg::ST_PRESSED;
            end
         end
         srsm_pkg::ST_PRESSED: begin
            if (!ok) begin
               next_state = srsm_pkg::ST_WAIT;
            end else if (!start) begin
               next_state = srsm_pkg::ST_DELAY;
            end
         end
         srsm_pkg::ST_DELAY: begin
            if (!ok) begin
               next_state = srsm_pkg::ST_WAIT;
            end else if (delay_cnt >= ON_CYC - 1) begin
               next_state = srsm_pkg::ST_ON;
            end
         end
         srsm_pkg::ST_ON: begin
            if (!ok) begin
               next_state = srsm_pkg::ST_WAIT;
            end
         end
         default: begin
            next_state = srsm_pkg::ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= srsm_pkg::ST_WAIT;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         delay_cnt <= 32'h0;
      end else if (state == srsm_pkg::ST_DELAY) begin
         delay_cnt <= delay_cnt + 32'h1;
      end else begin
         delay_cnt <= 32'h0;
      end
   end

   // Registered from next_state so contacts change in step with the state and drop with ok
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         relay_o <= 1'b0;
         aux_status_output_o <= 1'b0;
      end else begin
         relay_o <= (next_state == srsm_pkg::ST_ON);
         aux_status_output_o <= (next_state == srsm_pkg::ST_ON);
      end
   end

   // Free-running so all blinking indicators share one phase, except ch2, which blinks inverted on a cross short
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         blink_cnt <= 32'h0;
         blink <= 1'b0;
      end else if (blink_cnt >= BLINK_CYC - 1) begin
         blink_cnt <= 32'h0;
         blink <= ~blink;
      end else begin
         blink_cnt <= blink_cnt + 32'h1;
      end
   end

   always_comb begin
      next_led = '0;
      // Each indicator is built on its own so errors and status overlap
      if (!err.shrt) begin
         next_led.power = db[`SRSM_IX_UV] ? blink : 1'b1;
         if (err.conn) begin
            next_led.ch1 = blink;
            next_led.ch2 = ~blink;
         end else begin
            next_led.ch1 = err.blk1 ? blink : ch1;
            next_led.ch2 = err.blk2 ? blink : ch2;
         end
         next_led.out = (next_state == srsm_pkg::ST_ON);
         next_led.rst = start;
         if (err.term || err.intf) begin
            next_led.fault = 1'b1;
         end else if (err.conn || err.mode || err.vert || err.blk1 || err.blk2) begin
            next_led.fault = blink;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         led_power_o <= 1'b0;
         first_channel_indicator_o <= 1'b0;
         second_channel_indicator_o <= 1'b0;
         led_output_o <= 1'b0;
         led_reset_o <= 1'b0;
         led_fault_o <= 1'b0;
      end else begin
         led_power_o <= next_led.power;
         first_channel_indicator_o <= next_led.ch1;
         second_channel_indicator_o <= next_led.ch2;
         led_output_o <= next_led.out;
         led_reset_o <= next_led.rst;
         led_fault_o <= next_led.fault;
      end
   end

   // Software can only force the contacts open, never close them
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl <= `SRSM_CTRL_RST;
      end else if (wr_i && addr_i == `SRSM_ADR_CTRL) begin
         ctrl <= {7'h00, wdata_i[`SRSM_CTRL_FORCE_OFF]};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            `SRSM_ADR_CTRL: begin
               rdata_o <= ctrl;
            end
            `SRSM_ADR_STATUS: begin
               rdata_o <= err;
            end
            `SRSM_ADR_STATE: begin
               rdata_o <= {relay_o, db[`SRSM_IX_UV], cfg_done, 2'h0, mode_cfg};
            end
            default: begin
               rdata_o <= 8'h00;
            end
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

endmodule

/* File: hw/srsm_defs.svh */
`ifndef SRSM_DEFS_SVH
`define SRSM_DEFS_SVH
// Timing figures, in their own units
`define SRSM_CLK_KHZ 125000
`define SRSM_DEB_US 1000
`define SRSM_SETTLE_MS 10
`define SRSM_ON_DELAY_MS 40
`define SRSM_BLINK_HALF_MS 250
// Synchronised input vector layout
`define SRSM_NIN 12
`define SRSM_IX_CH1 0
`define SRSM_IX_CH2 1
`define SRSM_IX_START 2
`define SRSM_IX_FB 3
`define SRSM_IX_CSHORT 4
`define SRSM_IX_TERM 5
`define SRSM_IX_INTF 6
`define SRSM_IX_UV 7
`define SRSM_IX_XSHORT 8
`define SRSM_IX_MODE_LO 9
`define SRSM_IX_MODE_HI 11
// Selector positions
`define SRSM_MODE_VERT 3'h0
`define SRSM_MODE_AUTO 3'h1
`define SRSM_MODE_MANUAL 3'h2
`define SRSM_MODE_RISE 3'h3
`define SRSM_MODE_FALL 3'h4
// Register port
`define SRSM_ADR_CTRL 2'h0
`define SRSM_ADR_STATUS 2'h1
`define SRSM_ADR_STATE 2'h2
`define SRSM_CTRL_RST 8'h00
`define SRSM_CTRL_FORCE_OFF 0
`endif

/* File: hw/srsm_pkg.sv */
package srsm_pkg;
   typedef enum logic [2:0] {
      ST_WAIT,
      ST_ARMED,
      ST_PRESSED,
      ST_DELAY,
      ST_ON
   } srsm_state_t;

   typedef struct packed {
      logic blk2;
      logic blk1;
      logic vert;
      logic mode;
      logic conn;
      logic intf;
      logic term;
      logic shrt;
   } srsm_err_t;

   typedef struct packed {
      logic power;
      logic ch1;
      logic ch2;
      logic out;
      logic rst;
      logic fault;
   } srsm_led_t;
endpackage

/* File: testbench/srsm_props.sv */
module srsm_props (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic first_input_channel_i,
   input wire logic second_input_channel_i,
   input wire logic start_reset_input_i,
   input wire logic feedback_i,
   input wire logic contact_short_i,
   input wire logic internal_fault_i,
   input wire logic relay_o,
   input wire logic aux_status_output_o,
   input wire logic led_power_o,
   input wire logic first_channel_indicator_o,
   input wire logic second_channel_indicator_o,
   input wire logic led_output_o,
   input wire logic led_reset_o,
   input wire logic led_fault_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   aux_follow_a:
   assert property (aux_status_output_o == relay_o) else $error("aux differs from relay");
   out_led_a:
   assert property (led_output_o == relay_o) else $error("output led differs from relay");
   short_dark_a:
   assert property (contact_short_i [*8] ##1 contact_short_i [*8] |->
      !led_power_o && !led_fault_o && !relay_o) else $error("short not dark");
   intf_off_a:
   assert property (internal_fault_i [*8] ##1 internal_fault_i [*4] |-> !relay_o && led_fault_o)
      else $error("internal fault not shown");
   start_gate_a:
   assert property ($rose(relay_o) |-> $past(first_input_channel_i, 8) &&
      $past(second_input_channel_i, 8)) else $error("relay on without closed inputs");
   ch1_dark_a:
   assert property ((!first_input_channel_i && !led_fault_o) [*8] ##1
      (!first_input_channel_i && !led_fault_o) [*4] |-> !first_channel_indicator_o)
      else $error("first channel led lit while open");
   ch2_dark_a:
   assert property ((!second_input_channel_i && !led_fault_o) [*8] ##1
      (!second_input_channel_i && !led_fault_o) [*4] |-> !second_channel_indicator_o)
      else $error("second channel led lit while open");
   reset_dark_a:
   assert property ((!start_reset_input_i && !led_fault_o) [*8] ##1
      (!start_reset_input_i && !led_fault_o) [*4] |-> !led_reset_o)
      else $error("reset led lit while start idle");
   fault_open_a:
   assert property (led_fault_o [*3] |-> !relay_o) else $error("relay on during fault");
   weld_hold_a:
   assert property ((!feedback_i && !relay_o) [*8] ##1 (!feedback_i && !relay_o) [*8] |=>
      !relay_o) else $error("restart with welded contacts");
endmodule

bind srsm_top srsm_props srsm_props_i (.*);

/* File: testbench/srsm_far.sv */
module srsm_far (
   input wire logic clk_i,
   input wire logic relay_i,
   input wire logic weld_i,
   input wire logic [1:0] gate_i,
   input wire logic press_i,
   output logic ch1_o,
   output logic ch2_o,
   output logic start_o,
   output logic fb_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ch1_o = 1'b0;
      ch2_o = 1'b0;
      start_o = 1'b0;
      fb_o = 1'b1;
   end
   always @(posedge clk_i) begin
      ch1_o <= gate_i[0];
      ch2_o <= gate_i[1];
      start_o <= press_i;
   end
   // Welded contacts never report release, so a restart must stay refused
   always @(posedge clk_i) fb_o <= !relay_i && !weld_i;
endmodule

/* File: testbench/safety_relay_status_monitor_bench.sv */
module safety_relay_status_monitor_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_n_i = 1'b0;
   logic first_input_channel_i, second_input_channel_i, start_reset_input_i, feedback_i;
   logic contact_short_i = 1'b0, terminator_i = 1'b1, internal_fault_i = 1'b0;
   logic undervolt_i = 1'b0, channel_short_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic press = 1'b0, weld = 1'b0;
   logic [2:0] mode_i = 3'h1;
   logic [1:0] addr_i = 2'h0, gate = 2'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o, rv;
   logic relay_o, aux_status_output_o, led_power_o, first_channel_indicator_o;
   logic second_channel_indicator_o, led_output_o, led_reset_o, led_fault_o;
   int error_cnt = 0, compares = 0, n;
   int ebit[4] = '{2, 1, 3, 0};
   int h[$];

   initial forever #4 clk_i = ~clk_i;
   // Short counts keep the run brief; all waits below derive from them
   srsm_top #(.DEB_CYC(4), .SETTLE_CYC(40), .ON_CYC(10), .BLINK_CYC(8)) srsm_top_i (.*);
   srsm_far srsm_far_i (.clk_i(clk_i), .relay_i(relay_o), .weld_i(weld), .gate_i(gate),
      .press_i(press), .ch1_o(first_input_channel_i), .ch2_o(second_input_channel_i),
      .start_o(start_reset_input_i), .fb_o(feedback_i));

   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task test_done;
      if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task wt(input int c);
      repeat (c) @(posedge clk_i);
   endtask
   task rreg(input logic [1:0] a);
      @(posedge clk_i) begin
         addr_i <= a;
         rd_i <= 1'b1;
      end
      @(posedge clk_i) rd_i <= 1'b0;
      @(negedge clk_i) rv = rdata_o;
   endtask
   task wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_i) begin
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
      end
      @(posedge clk_i) wr_i <= 1'b0;
   endtask
   task inj(input int k);
      @(posedge clk_i) begin
         internal_fault_i <= (k == 0);
         terminator_i <= (k != 1);
         channel_short_i <= (k == 2);
         contact_short_i <= (k == 3);
         undervolt_i <= (k == 5);
      end
   endtask
   task boot(input logic [2:0] m);
      @(posedge clk_i) begin
         rst_n_i <= 1'b0;
         mode_i <= m;
         gate <= 2'h0;
         press <= 1'b0;
         weld <= 1'b0;
      end
      inj(4);
      wt(1);
      @(posedge clk_i) rst_n_i <= 1'b1;
      wt(60);
   endtask
   task pwr(output int c);
      c = 0;
      repeat (20) @(negedge clk_i) c += led_power_o;
   endtask
   task close_wait;
      @(posedge clk_i) gate <= 2'h3;
      wt(40);
      @(negedge clk_i);
   endtask
   // Start model: a press is needed outside auto mode, falling mode also needs release
   function automatic logic mrel(input int m);
      if (m == 1) return 1'b1;
      return (m == 4) ? h.size() > 1 : h.size() > 0;
   endfunction

   initial begin
      wt(20000);
      error_cnt++;
      test_done;
   end

   initial begin
      void'($urandom(32'h1a60));
      @(negedge clk_i);
      chk("relay_rst", relay_o, 1'b0);
      boot(3'h1);
      pwr(n);
      chk("power_on", 8'(n), 8'h14);
      rreg(2'h0);
      chk("ctrl_rst", rv, 8'h00);
      wreg(2'h1, 8'($urandom));
      rreg(2'h1);
      chk("status_ro", rv, 8'h00);
      rreg(2'h3);
      chk("unmapped", rv, 8'h00);
      rreg(2'h2);
      chk("state", rv, 8'h21);
      close_wait;
      chk("auto", relay_o, mrel(1));
      chk("aux", aux_status_output_o, 1'b1);
      chk("ch1_led", first_channel_indicator_o, 1'b1);
      chk("ch2_led", second_channel_indicator_o, 1'b1);
      wreg(2'h0, 8'h01);
      wt(10);
      @(negedge clk_i) chk("forced", relay_o, 1'b0);
      wreg(2'h0, 8'h00);
      close_wait;
      chk("unforced", relay_o, 1'b1);
      for (int c = 0; c < 2; c++) begin
         @(posedge clk_i) gate <= 2'h3 ^ (2'h1 << c);
         wt(20);
         close_wait;
         chk("blocked", relay_o, 1'b0);
         rreg(2'h1);
         chk("blk_flag", rv, 8'h40 << c);
         @(posedge clk_i) gate <= 2'h0;
         wt(20);
         close_wait;
         chk("unblocked", relay_o, 1'b1);
      end
      @(posedge clk_i) mode_i <= 3'h2;
      wt(30);
      @(negedge clk_i) chk("mode_chg", relay_o, 1'b0);
      @(posedge clk_i) mode_i <= 3'h1;
      wt(30);
      rreg(2'h1);
      chk("mode_err", rv, 8'h10);
      boot(3'h1);
      close_wait;
      @(posedge clk_i) begin
         weld <= 1'b1;
         gate <= 2'h0;
      end
      wt(20);
      close_wait;
      chk("welded", relay_o, 1'b0);
      for (int m = 2; m < 5; m++) begin
         h.delete();
         boot(3'(m));
         close_wait;
         chk("no_press", relay_o, mrel(m));
         @(posedge clk_i) press <= (m > 1);
         h.push_back(1);
         wt(40);
         @(negedge clk_i) chk("pressed", relay_o, mrel(m));
         chk("rst_led", led_reset_o, 1'b1);
         @(posedge clk_i) press <= (m < 2);
         h.push_back(0);
         wt(40);
         @(negedge clk_i) chk("released", relay_o, mrel(m));
      end
      boot(3'h0);
      close_wait;
      chk("vert_off", relay_o, 1'b0);
      rreg(2'h1);
      chk("vert_err", rv, 8'h20);
      boot(3'($urandom_range(7, 5)));
      rreg(2'h1);
      chk("bad_mode", rv, 8'h10);
      for (int k = 0; k < 4; k++) begin
         boot(3'h1);
         close_wait;
         inj(k);
         wt(30);
         @(negedge clk_i) chk("err_off", relay_o, 1'b0);
         if (k < 2) chk("fault_led", led_fault_o, 1'b1);
         if (k == 2) chk("alternate", first_channel_indicator_o ^ second_channel_indicator_o,
            1'b1);
         if (k == 3) chk("dark", 8'({led_power_o, led_fault_o, led_output_o, led_reset_o,
            first_channel_indicator_o, second_channel_indicator_o}), 8'h00);
         inj(4);
         wt(30);
         rreg(2'h1);
         chk("latched", rv, 8'h01 << ebit[k]);
      end
      boot(3'h1);
      inj(5);
      wt(30);
      pwr(n);
      chk("uv_blink", 8'(n > 0 && n < 20), 8'h01);
      chk("uv_fault", led_fault_o, 1'b0);
      test_done;
   end
endmodule
